/* File: rtl/timer16_capture_compare.sv */
// 16-bit timer core: clock select, counter, compare, capture, flags and registers
// Operation
// - with filter on, capture level changes only after four equal samples
// - edge select bit: zero picks falling edges, one picks rising edges
// - capture trigger copies counter into capture value and sets capture flag
// - when capture value is TOP, pin capture events are disabled
// - clock select: stop, divide 1/8/64/256/1024, external falling, external rising
// - external count pin edges count even when that pin is an output
// - force bit in non-PWM modes forces a compare match on the waveform
// - forced match sets no flag, raises no interrupt, never clears counter
// - force bits are strobes and always read back as zero
// - 16-bit registers move through one shared high-byte latch
// - counter write blocks compare matches on the next timer clock
// - compare registers are compared with the counter continuously
// - capture source is the pin or optionally the analog comparator
// - interrupt request when flag, enable bit and global enable are set
// - with capture value as TOP, capture flag sets when counter hits TOP
// - compare flag sets in the timer clock after counter equals compare
// - flags clear on vector execution or when software writes one
// - overflow flag sets on overflow in Normal/CTC, else per mode point
// - waveform mode picks TOP source, overflow point and compare update point
`include "timer16_map.svh"
module timer16_capture_compare
  import timer16_pkg::*;
(
  input  wire logic       ref_clk_i,            // clock, 50 MHz
  input  wire logic       reset_n_i,            // sync reset, active low
  input  wire logic [7:0] addr_i,               // register location
  input  wire logic [7:0] wdata_i,              // write data
  input  wire logic       wr_i,                 // write strobe
  input  wire logic       rd_i,                 // read strobe
  output logic      [7:0] rdata_o,              // read data, next cycle
  input  wire logic       capture_pin_i,        // capture pin, async
  input  wire logic       comparator_out_i,     // analog comparator, async
  input  wire logic       comparator_select_i,  // capture from comparator
  input  wire logic       ext_count_pin_i,      // external count pin, async
  input  wire logic       global_int_enable_i,  // global interrupt enable
  input  wire logic [3:0] vector_ack_i,         // vector executed: cap,B,A,ovf
  output logic      [3:0] irq_o,                // requests: cap,B,A,ovf
  output logic            compare_a_out_o,      // compare A waveform
  output logic            compare_b_out_o       // compare B waveform
);
  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0]      ctrl_a;
  logic [7:0]      ctrl_b;
  logic [3:0]      mask_v;
  logic [3:0]      flag_v;
  logic [7:0]      temp;
  word_t           cnt;
  word_t           cap_val;
  word_t           ocr_buf [2];
  word_t           ocr_act [2];
  logic [1:0]      force_v;
  logic [1:0]      wave;
  logic            count_up;
  logic            block;
  logic [`PRE_W-1:0] prescale;
  logic            ext_meta;
  logic            ext_sync;
  logic            ext_prev;
  logic [7:0]      rdata;
  logic [3:0]      irq;

  capture_if cap ();

  ////////////////////////////////////////////////////////////////////////////
  // decoding
  function automatic wave_kind_t kind_of(input logic [3:0] m);
    unique case (m)
      4'd4, 4'd12:                       kind_of = KIND_CTC;
      4'd5, 4'd6, 4'd7, 4'd14, 4'd15:    kind_of = KIND_FAST;
      4'd0, 4'd13:                       kind_of = KIND_NORMAL;
      default:                           kind_of = KIND_PHASE;
    endcase
  endfunction

  // four flag/enable bits live at scattered positions of a byte
  function automatic logic [7:0] pack4(input logic [3:0] v);
    pack4 = 8'h00;
    pack4[`BIT_CAP]  = v[3];
    pack4[`BIT_CMPB] = v[2];
    pack4[`BIT_CMPA] = v[1];
    pack4[`BIT_OVF]  = v[0];
  endfunction

  function automatic logic [3:0] unpack4(input logic [7:0] b);
    unpack4 = {b[`BIT_CAP], b[`BIT_CMPB], b[`BIT_CMPA], b[`BIT_OVF]};
  endfunction

  logic [3:0] mode;
  wave_kind_t kind;
  word_t      top;
  logic       icr_top;
  logic       pwm;
  assign mode    = {ctrl_b[4:3], ctrl_a[1:0]};
  assign kind    = kind_of(mode);
  assign pwm     = kind == KIND_FAST || kind == KIND_PHASE;
  assign icr_top = mode == 4'd8 || mode == 4'd10 || mode == 4'd12 || mode == 4'd14;

  always_comb begin
    unique case (mode)
      4'd1, 4'd5:                  top = `TOP_8BIT;
      4'd2, 4'd6:                  top = `TOP_9BIT;
      4'd3, 4'd7:                  top = `TOP_10BIT;
      4'd4, 4'd9, 4'd11, 4'd15:    top = ocr_act[0];
      4'd8, 4'd10, 4'd12, 4'd14:   top = cap_val;
      default:                     top = `TOP_MAX;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock select
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      prescale <= '0;
    end else begin
      prescale <= prescale + `PRE_W'(1);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      ext_meta <= ext_count_pin_i;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  logic tick;
  always_comb begin
    // pin is read regardless of its direction, so software can drive it
    unique case (ctrl_b[2:0])
      3'd0: tick = 1'b0;
      3'd1: tick = 1'b1;
      3'd2: tick = &prescale[`PRE_TAP_8-1:0];
      3'd3: tick = &prescale[`PRE_TAP_64-1:0];
      3'd4: tick = &prescale[`PRE_TAP_256-1:0];
      3'd5: tick = &prescale[`PRE_TAP_1024-1:0];
      3'd6: tick = ext_prev && !ext_sync;
      3'd7: tick = !ext_prev && ext_sync;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  logic cnt_wr;
  logic cap_wr;
  logic [1:0] ocr_wr;
  assign cnt_wr    = wr_i && addr_i == `ADDR_CNT_L;
  assign cap_wr    = wr_i && addr_i == `ADDR_CAP_L;
  assign ocr_wr[0] = wr_i && addr_i == `ADDR_CMPA_L;
  assign ocr_wr[1] = wr_i && addr_i == `ADDR_CMPB_L;

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      ctrl_a <= `RESET_CTRL;
      ctrl_b <= `RESET_CTRL;
      mask_v <= '0;
    end else if (wr_i) begin
      if (addr_i == `ADDR_CTRL_A) ctrl_a <= wdata_i;
      if (addr_i == `ADDR_CTRL_B) ctrl_b <= wdata_i & ~(8'h01 << `BIT_RSV);
      if (addr_i == `ADDR_MASK)   mask_v <= unpack4(wdata_i);
    end
  end

  // high byte written first, taken together with the low byte
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      temp <= 8'h00;
    end else if (wr_i && (addr_i == `ADDR_CNT_H || addr_i == `ADDR_CAP_H ||
                          addr_i == `ADDR_CMPA_H || addr_i == `ADDR_CMPB_H)) begin
      temp <= wdata_i;
    end else if (rd_i) begin
      unique case (addr_i)
        `ADDR_CNT_L:  temp <= cnt[15:8];
        `ADDR_CAP_L:  temp <= cap_val[15:8];
        `ADDR_CMPA_L: temp <= ocr_buf[0][15:8];
        `ADDR_CMPB_L: temp <= ocr_buf[1][15:8];
        default:      temp <= temp;
      endcase
    end
  end

  // force bits are strobes: one cycle, only outside PWM
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      force_v <= 2'b00;
    end else begin
      force_v <= (wr_i && addr_i == `ADDR_CTRL_C && !pwm) ?
                 {wdata_i[`BIT_FORCE_B], wdata_i[`BIT_FORCE_A]} : 2'b00;
    end
  end

  logic [7:0] next_rdata;
  always_comb begin
    unique case (addr_i)
      `ADDR_CTRL_A: next_rdata = ctrl_a;
      `ADDR_CTRL_B: next_rdata = ctrl_b;
      `ADDR_CTRL_C: next_rdata = 8'h00;
      `ADDR_CNT_L:  next_rdata = cnt[7:0];
      `ADDR_CAP_L:  next_rdata = cap_val[7:0];
      `ADDR_CMPA_L: next_rdata = ocr_buf[0][7:0];
      `ADDR_CMPB_L: next_rdata = ocr_buf[1][7:0];
      `ADDR_CNT_H, `ADDR_CAP_H, `ADDR_CMPA_H, `ADDR_CMPB_H: next_rdata = temp;
      `ADDR_MASK:   next_rdata = pack4(mask_v);
      `ADDR_FLAGS:  next_rdata = pack4(flag_v);
      default:      next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      rdata <= 8'h00;
    end else if (rd_i) begin
      rdata <= next_rdata;
    end
  end
  assign rdata_o = rdata;

  ////////////////////////////////////////////////////////////////////////////
  // counter
  logic top_hit;
  logic bottom_hit;
  assign top_hit    = tick && cnt == top && (kind != KIND_PHASE || count_up);
  assign bottom_hit = tick && kind == KIND_PHASE && !count_up && cnt == `RESET_WORD;

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      cnt      <= `RESET_WORD;
      count_up <= 1'b1;
    end else if (cnt_wr) begin
      cnt <= {temp, wdata_i};
    end else if (tick) begin
      if (kind != KIND_PHASE) begin
        cnt <= (cnt == top) ? `RESET_WORD : cnt + 16'h0001;
      end else if (count_up) begin
        if (cnt >= top) begin
          count_up <= 1'b0;
          cnt      <= cnt - 16'h0001;
        end else begin
          cnt <= cnt + 16'h0001;
        end
      end else if (cnt == `RESET_WORD) begin
        count_up <= 1'b1;
        cnt      <= cnt + 16'h0001;
      end else begin
        cnt <= cnt - 16'h0001;
      end
    end
  end

  // a counter write hides the compare on the following timer clock
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      block <= 1'b0;
    end else if (cnt_wr) begin
      block <= 1'b1;
    end else if (tick) begin
      block <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare units
  logic [1:0] match;
  logic       upd;
  assign upd = !pwm ? 1'b1 :
               kind == KIND_FAST ? top_hit :
               (mode == 4'd8 || mode == 4'd9) ? bottom_hit : top_hit;

  for (genvar i = 0; i < 2; i++) begin : g_unit
    logic [1:0] com;
    logic       toggle_ok;
    assign com       = ctrl_a[7-2*i -: 2];
    assign toggle_ok = i == 0 && (mode == 4'd9 || mode == 4'd11 || mode >= 4'd14);
    assign match[i]  = tick && !block && !cnt_wr && cnt == ocr_act[i];

    always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
        ocr_buf[i] <= `RESET_WORD;
        ocr_act[i] <= `RESET_WORD;
      end else begin
        if (ocr_wr[i]) ocr_buf[i] <= {temp, wdata_i};
        if (upd)       ocr_act[i] <= ocr_wr[i] && !pwm ? {temp, wdata_i} : ocr_buf[i];
      end
    end

    always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
        wave[i] <= 1'b0;
      end else if (!pwm) begin
        if (match[i] || force_v[i]) begin
          unique case (com)
            2'b00: wave[i] <= wave[i];
            2'b01: wave[i] <= !wave[i];
            2'b10: wave[i] <= 1'b0;
            2'b11: wave[i] <= 1'b1;
          endcase
        end
      end else if (com == 2'b01) begin
        if (match[i] && toggle_ok) wave[i] <= !wave[i];
      end else if (com[1]) begin
        if (match[i]) begin
          wave[i] <= kind == KIND_FAST ? com[0] : (count_up ? com[0] : !com[0]);
        end else if (kind == KIND_FAST && top_hit) begin
          wave[i] <= !com[0];
        end
      end
    end
  end
  assign compare_a_out_o = wave[0];
  assign compare_b_out_o = wave[1];

  ////////////////////////////////////////////////////////////////////////////
  // capture
  assign cap.filter_enable  = ctrl_b[`BIT_FILTER];
  assign cap.edge_select    = ctrl_b[`BIT_EDGE];
  assign cap.capture_enable = !icr_top;

  capture_cond u_capture_cond (
    .ref_clk_i           (ref_clk_i),
    .reset_n_i           (reset_n_i),
    .capture_pin_i       (capture_pin_i),
    .comparator_out_i    (comparator_out_i),
    .comparator_select_i (comparator_select_i),
    .cap                 (cap)
  );

  // a pin capture outranks a software write to the same register
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      cap_val <= `RESET_WORD;
    end else if (cap.trigger && !icr_top) begin
      cap_val <= cnt;
    end else if (cap_wr) begin
      cap_val <= {temp, wdata_i};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags and requests
  logic [3:0] set_v;
  logic [3:0] w1c_v;
  assign set_v[3] = icr_top ? top_hit : cap.trigger;
  assign set_v[2] = match[1];
  assign set_v[1] = match[0];
  assign set_v[0] = (kind == KIND_NORMAL || kind == KIND_CTC) ?
                    tick && cnt == `TOP_MAX :
                    kind == KIND_FAST ? top_hit : bottom_hit;
  assign w1c_v = (wr_i && addr_i == `ADDR_FLAGS) ? unpack4(wdata_i) : 4'h0;

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      flag_v <= 4'h0;
    end else begin
      flag_v <= (flag_v & ~w1c_v & ~vector_ack_i) | set_v;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      irq <= 4'h0;
    end else begin
      irq <= flag_v & mask_v & {4{global_int_enable_i}};
    end
  end
  assign irq_o = irq;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  capture_copy_a: assert property (cap.trigger && !icr_top |=>
    cap_val == $past(cnt) && flag_v[3])
    else $error("capture did not copy counter and set flag");
  capture_off_a: assert property (icr_top && !top_hit && !cap_wr |=>
    $stable(cap_val) && !$rose(flag_v[3]))
    else $error("capture ran while capture value is TOP");
  reserved_zero_a: assert property (rd_i && addr_i == `ADDR_CTRL_B |=>
    !rdata_o[`BIT_RSV])
    else $error("reserved bit read nonzero");
  force_read_a: assert property (rd_i && addr_i == `ADDR_CTRL_C |=>
    rdata_o == 8'h00)
    else $error("force bits read back nonzero");
  force_silent_a: assert property (force_v[0] && !match[0] |=>
    !$rose(flag_v[1]))
    else $error("forced compare set the match flag");
  block_match_a: assert property (tick && (block || cnt_wr) |->
    !match[0] && !match[1])
    else $error("compare match after counter write");
  match_flag_a: assert property (tick && !block && !cnt_wr && cnt == ocr_act[1] |=>
    flag_v[2])
    else $error("compare B flag missed");
  flag_clear_a: assert property (w1c_v[0] && !set_v[0] |=> !flag_v[0])
    else $error("overflow flag not cleared by write one");
  irq_gate_a: assert property (##1 irq_o[1] ==
    $past(flag_v[1] && mask_v[1] && global_int_enable_i))
    else $error("compare A request does not follow flag and enables");

  capture_seen_c: cover property (cap.trigger ##1 flag_v[3]);
  overflow_seen_c: cover property ($rose(flag_v[0]) ##1 irq_o[0]);
  force_seen_c: cover property (force_v[0] && ctrl_a[7:6] == 2'b01);
  phase_turn_c: cover property (kind == KIND_PHASE && $fell(count_up));
endmodule // timer16_capture_compare

/* File: rtl/timer16_map.svh */
// register offsets, bit positions, reset values and counts of the 16-bit timer
`ifndef TIMER16_MAP_SVH
`define TIMER16_MAP_SVH
`define ADDR_CTRL_A    8'h80
`define ADDR_CTRL_B    8'h81
`define ADDR_CTRL_C    8'h82
`define ADDR_CNT_L     8'h84
`define ADDR_CNT_H     8'h85
`define ADDR_CAP_L     8'h86
`define ADDR_CAP_H     8'h87
`define ADDR_CMPA_L    8'h88
`define ADDR_CMPA_H    8'h89
`define ADDR_CMPB_L    8'h8A
`define ADDR_CMPB_H    8'h8B
`define ADDR_MASK      8'h6F
`define ADDR_FLAGS     8'h36
`define BIT_FILTER     7
`define BIT_EDGE       6
`define BIT_RSV        5
`define BIT_FORCE_A    7
`define BIT_FORCE_B    6
`define BIT_CAP        5
`define BIT_CMPB       2
`define BIT_CMPA       1
`define BIT_OVF        0
`define RESET_CTRL     8'h00
`define RESET_WORD     16'h0000
`define FILTER_SAMPLES 4
`define PRE_W          10
`define PRE_TAP_8      3
`define PRE_TAP_64     6
`define PRE_TAP_256    8
`define PRE_TAP_1024   10
`define TOP_MAX        16'hFFFF
`define TOP_8BIT       16'h00FF
`define TOP_9BIT       16'h01FF
`define TOP_10BIT      16'h03FF
`endif

/* File: rtl/timer16_pkg.sv */
// types shared by the 16-bit timer modules
package timer16_pkg;
  typedef logic [15:0] word_t;
  typedef enum logic [1:0] {KIND_NORMAL, KIND_CTC, KIND_FAST, KIND_PHASE} wave_kind_t;
endpackage

/* File: rtl/capture_if.sv */
// capture conditioner to timer core carrier
interface capture_if;
  logic filter_enable;
  logic edge_select;
  logic capture_enable;
  logic trigger;
  modport core (output filter_enable, output edge_select, output capture_enable,
                input trigger);
  modport cond (input filter_enable, input edge_select, input capture_enable,
                output trigger);
endinterface

/* File: rtl/capture_cond.sv */
// capture pin synchroniser, noise filter and edge detector
`include "timer16_map.svh"
module capture_cond (
  input  wire logic ref_clk_i,            // reference clock
  input  wire logic reset_n_i,            // sync reset, active low
  input  wire logic capture_pin_i,        // capture pin, async
  input  wire logic comparator_out_i,     // analog comparator output, async
  input  wire logic comparator_select_i,  // take comparator instead of pin
  capture_if.cond   cap                   // to timer core
);
  logic                         src_meta;
  logic                         src_sync;
  logic [`FILTER_SAMPLES-1:0]   samples;
  logic                         filtered;
  logic                         trigger;

  // mux ahead of the synchroniser so only one async path is sampled
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      src_meta <= 1'b0;
      src_sync <= 1'b0;
    end else begin
      src_meta <= comparator_select_i ? comparator_out_i : capture_pin_i;
      src_sync <= src_meta;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      samples  <= '0;
      filtered <= 1'b0;
    end else begin
      samples <= {samples[`FILTER_SAMPLES-2:0], src_sync};
      if (!cap.filter_enable) begin
        filtered <= src_sync;
      end else if (&samples || ~|samples) begin
        filtered <= samples[0];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      trigger <= 1'b0;
    end else begin
      // edge seen on the filtered level; disabled capture drops it here
      trigger <= cap.capture_enable && (samples[0] != filtered || !cap.filter_enable)
                 && (cap.filter_enable ? samples[0] : src_sync) == cap.edge_select
                 && (cap.filter_enable ? (&samples || ~|samples) : src_sync != filtered);
    end
  end
  assign cap.trigger = trigger;

  filter_hold_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    cap.filter_enable && $past(cap.filter_enable) && $changed(filtered)
      |-> $past(&samples || ~|samples))
    else $error("filtered capture level changed without four equal samples");
  edge_dir_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    trigger |-> filtered == $past(cap.edge_select))
    else $error("capture triggered on the wrong edge");
endmodule // capture_cond

/* File: tb/pin_model.sv */
// model of the external capture pin and count pin
module pin_model (
  input  wire logic ref_clk_i,     // bench clock
  input  wire logic cap_flip_i,    // flip capture pin level
  input  wire logic cap_glitch_i,  // two-cycle spike on capture pin
  input  wire logic cnt_flip_i,    // flip count pin level
  output logic      cap_pin_o,     // capture pin
  output logic      cnt_pin_o      // external count pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       cap_lvl = 1'b0;
  logic [1:0] spike   = 2'b00;
  logic       cnt_lvl = 1'b0;
  // the spike is shorter than the filter window, so a filtered input must ignore it
  always @(posedge ref_clk_i) begin
    if (cap_flip_i) cap_lvl <= ~cap_lvl;
    spike <= cap_glitch_i ? 2'b11 : (spike >> 1);
    if (cnt_flip_i) cnt_lvl <= ~cnt_lvl;
  end
  assign cap_pin_o = cap_lvl ^ spike[0];
  assign cnt_pin_o = cnt_lvl;
endmodule // pin_model

/* File: tb/test_timer16_capture_compare.sv */
// self-checking bench for the 16-bit timer register block
`include "timer16_map.svh"
module test_timer16_capture_compare import timer16_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 1'b0, reset_n = 1'b0, wr = 1'b0, rd = 1'b0, gie = 1'b0;
  logic       csel = 1'b0, cmp = 1'b0;
  logic       cap_pin, cnt_pin, out_a, out_b;
  logic [2:0] poke = 3'h0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, b;
  logic [3:0] ack = 4'h0, irq;
  int         err_total = 0, checks = 0, cycles = 0, e;
  word_t      w;
  int         sh[5] = '{0, 3, 6, 8, 10};
  int         xc[4] = '{1, 1, 1, 2};
  logic [7:0] lo[4];

  always #10 clk = ~clk;

  timer16_capture_compare u_dut (
    .ref_clk_i(clk), .reset_n_i(reset_n), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .capture_pin_i(cap_pin),
    .comparator_out_i(cmp), .comparator_select_i(csel),
    .ext_count_pin_i(cnt_pin), .global_int_enable_i(gie),
    .vector_ack_i(ack), .irq_o(irq), .compare_a_out_o(out_a),
    .compare_b_out_o(out_b));

  pin_model u_pins (
    .ref_clk_i(clk), .cap_flip_i(poke[0]), .cap_glitch_i(poke[1]),
    .cnt_flip_i(poke[2]), .cap_pin_o(cap_pin), .cnt_pin_o(cnt_pin));

  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd8(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // high byte first on write, low byte first on read, through the shared latch
  task automatic wr16(input logic [7:0] a, input word_t v);
    wr8(a + 8'h01, v[15:8]);
    wr8(a, v[7:0]);
  endtask

  task automatic rd16(input logic [7:0] a, output word_t v);
    rd8(a, v[7:0]);
    rd8(a + 8'h01, v[15:8]);
  endtask

  task automatic chk(input logic [15:0] s, input logic [15:0] x);
    checks++;
    if (s !== x) begin
      err_total++;
      $display("mismatch at %0t: got %h want %h", $time, s, x);
    end
  endtask

  task automatic pulse(input int k);
    @(posedge clk);
    poke[k] <= 1'b1;
    @(posedge clk);
    poke <= 3'h0;
  endtask

  task automatic cap_step(input int k, input word_t c, input logic [7:0] f);
    pulse(k);
    tick(12);
    rd16(`ADDR_CAP_L, w);
    chk(w, c);
    rd8(`ADDR_FLAGS, b);
    chk(b, f);
  endtask

  task automatic run(input logic [7:0] cs, input int n);
    wr8(`ADDR_CTRL_B, cs);
    tick(n);
    wr8(`ADDR_CTRL_B, 8'h00);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // the run should take about 21000 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      err_total++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    lo = '{`ADDR_CNT_L, `ADDR_CAP_L, `ADDR_CMPA_L, `ADDR_CMPB_L};
    tick(12);
    reset_n <= 1'b1;
    rd8(`ADDR_CTRL_B, b);
    chk(b, 8'h00);
    wr8(`ADDR_CTRL_B, 8'h20);
    rd8(`ADDR_CTRL_B, b);
    chk(b, 8'h00);
    wr8(`ADDR_CTRL_C, 8'hC0);
    rd8(`ADDR_CTRL_C, b);
    chk(b, 8'h00);
    rd8(8'h83, b);
    chk(b, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr16(lo[i], 16'h1111 * word_t'(i + 1));
      rd16(lo[i], w);
      chk(w, 16'h1111 * word_t'(i + 1));
    end
    $display("test registers done");
    for (int cs = 1; cs <= 5; cs++) begin
      wr16(`ADDR_CNT_L, 16'h0000);
      run(8'(cs), 4096);
      e = 4098 >> sh[cs - 1];
      rd16(`ADDR_CNT_L, w);
      chk(16'((w >= e - 1) && (w <= e + 1)), 16'h0001);
      tick(40);
      rd8(`ADDR_CNT_L, b);
      chk(b, w[7:0]);
    end
    wr16(`ADDR_CNT_L, 16'h0000);
    wr8(`ADDR_CTRL_B, 8'h07);
    for (int i = 0; i < 4; i++) begin
      if (i == 2) wr8(`ADDR_CTRL_B, 8'h06);
      pulse(2);
      tick(8);
      rd16(`ADDR_CNT_L, w);
      chk(w, 16'(xc[i]));
    end
    $display("test clock select done");
    wr8(`ADDR_CTRL_B, 8'hC0);
    wr16(`ADDR_CNT_L, 16'h0055);
    wr8(`ADDR_FLAGS, 8'h27);
    cap_step(1, 16'h2222, 8'h00);
    cap_step(0, 16'h0055, 8'h20);
    wr8(`ADDR_MASK, 8'h20);
    gie <= 1'b1;
    tick(3);
    chk(irq, 4'h8);
    gie <= 1'b0;
    tick(3);
    chk(irq, 4'h0);
    gie <= 1'b1;
    ack <= 4'h8;
    tick(1);
    ack <= 4'h0;
    tick(3);
    chk(irq, 4'h0);
    rd8(`ADDR_FLAGS, b);
    chk(b, 8'h00);
    wr16(`ADDR_CNT_L, 16'h0066);
    cap_step(0, 16'h0055, 8'h00);
    wr8(`ADDR_CTRL_B, 8'h80);
    cap_step(0, 16'h0055, 8'h00);
    cap_step(0, 16'h0066, 8'h20);
    wr16(`ADDR_CNT_L, 16'h0077);
    csel <= 1'b1;
    cmp <= 1'b1;
    tick(12);
    cmp <= 1'b0;
    tick(12);
    rd16(`ADDR_CAP_L, w);
    chk(w, 16'h0077);
    csel <= 1'b0;
    wr8(`ADDR_FLAGS, 8'h20);
    $display("test capture done");
    wr8(`ADDR_MASK, 8'h27);
    wr8(`ADDR_CTRL_A, 8'h50);
    wr8(`ADDR_CTRL_C, 8'h80);
    tick(2);
    chk({out_a, out_b}, 2'b10);
    wr8(`ADDR_CTRL_C, 8'h40);
    tick(2);
    chk({out_a, out_b}, 2'b11);
    rd8(`ADDR_FLAGS, b);
    chk(b, 8'h00);
    chk(irq, 4'h0);
    $display("test force done");
    wr16(`ADDR_CMPA_L, 16'h0014);
    wr16(`ADDR_CNT_L, 16'h0014);
    run(8'h01, 6);
    rd8(`ADDR_FLAGS, b);
    chk(b, 8'h00);
    wr16(`ADDR_CNT_L, 16'h0010);
    run(8'h01, 6);
    rd8(`ADDR_FLAGS, b);
    chk(b, 8'h02);
    chk(irq, 4'h2);
    wr8(`ADDR_FLAGS, 8'h27);
    wr16(`ADDR_CNT_L, 16'hFFF8);
    run(8'h01, 12);
    rd8(`ADDR_FLAGS, b);
    chk(b, 8'h01);
    $display("test compare done");
    // fast pwm with capture value as top: pin events must not capture
    wr8(`ADDR_FLAGS, 8'h27);
    wr16(`ADDR_CAP_L, 16'h0020);
    wr16(`ADDR_CNT_L, 16'h0000);
    wr8(`ADDR_CTRL_A, 8'h02);
    wr8(`ADDR_CTRL_C, 8'h00);
    wr8(`ADDR_CTRL_B, 8'h59);
    pulse(0);
    tick(60);
    rd8(`ADDR_FLAGS, b);
    chk(b, 8'h23);
    rd16(`ADDR_CAP_L, w);
    chk(w, 16'h0020);
    $display("test pwm done");
    tally_and_finish();
  end
endmodule // test_timer16_capture_compare
